// *** esq_pkg.sv ***
// shared constants and types for the sequencer
package esq_pkg;
   // region geometry and counter widths
   localparam int NUM_ROI = 8;
   localparam int KERNEL_PIXELS = 8;
   localparam int COL_W = 8;
   localparam int ROW_W = 10;
   localparam int PIX_COL_W = COL_W + 3;
   localparam int TIME_W = 16;
   localparam int CYC_W = 10;

   // reference clock and timer unit figures
   localparam real REF_CLK_MHZ = 20.0;
   localparam real REF_CLK_PERIOD_NS = 1000.0 / REF_CLK_MHZ;
   localparam real UNIT_SERIAL_NS = 16.129;
   localparam real UNIT_SERIAL_MHZ = 62.0;
   localparam real UNIT_PARALLEL_NS = 64.516;

   // minimum trigger high time in reference cycles
   localparam real TRIG_MIN_HIGH_NS = 100.0;
   localparam int TRIG_MIN_HIGH_CYCLES =
      (int'($ceil(TRIG_MIN_HIGH_NS / REF_CLK_PERIOD_NS)) < 1) ? 1 :
      int'($ceil(TRIG_MIN_HIGH_NS / REF_CLK_PERIOD_NS));

   // overhead durations in reference cycles
   localparam logic [CYC_W-1:0] FOT_CYCLES = 10'h010;
   localparam logic [CYC_W-1:0] ROT_CYCLES = 10'h004;

   // flag pin source selection
   localparam logic [2:0] FLAG_SRC_FIRST_LINE = 3'h5;

   // shutter modes
   localparam logic [1:0] MODE_PIPELINED = 2'h0;
   localparam logic [1:0] MODE_TRIGGERED = 2'h1;
   localparam logic [1:0] MODE_SLAVE = 2'h2;
   localparam logic [1:0] MODE_ROLLING = 2'h3;

   typedef enum logic [2:0] {
      RD_IDLE, RD_FOT, RD_ROT, RD_LINE, RD_PAD
   } esq_rd_state_t;

   typedef enum logic [2:0] {
      EX_IDLE, EX_RESET, EX_SYNC, EX_RUN, EX_HOLD
   } esq_ex_state_t;
endpackage

// *** esq_unit_timer.sv ***
// prescaled down-counter for reset span and exposure durations
`timescale 1ns/1ps
module esq_unit_timer
   import esq_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // control
   input wire logic load_i,
   input wire logic [TIME_W-1:0] value_i,
   input wire logic [TIME_W-1:0] mult_i,
   // status
   output logic expired_o
);
   logic [TIME_W-1:0] pre;
   logic [TIME_W-1:0] next_pre;
   logic [TIME_W-1:0] cnt;
   logic [TIME_W-1:0] next_cnt;
   logic run;
   logic next_run;
   logic tick;

   always_comb begin
      tick = 1'b0;
      next_pre = pre;
      next_cnt = cnt;
      next_run = run;
      expired_o = 1'b0;
      if (load_i) begin
         // prescaler restarts with every load
         next_pre = 16'h0000; // [RULE23]
         next_cnt = value_i;
         next_run = 1'b1;
      end else if (run) begin
         // multiplier of zero acts as one
         if (pre + 16'h0001 >= mult_i) begin
            tick = 1'b1;
            next_pre = 16'h0000;
         end else begin
            next_pre = pre + 16'h0001;
         end
         if (cnt == 16'h0000) begin
            expired_o = 1'b1;
            next_run = 1'b0;
         end else if (tick) begin
            next_cnt = cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         pre <= 16'h0000;
         cnt <= 16'h0000;
         run <= 1'b0;
      end else begin
         pre <= next_pre;
         cnt <= next_cnt;
         run <= next_run;
      end
   end
endmodule

// *** esq_roi_scan.sv ***
// region lookup: row coverage, row stepping and kernel column stepping
`timescale 1ns/1ps
module esq_roi_scan
   import esq_pkg::*;
(
   // region settings
   input wire logic [NUM_ROI-1:0] roi_enable_i,
   input wire logic single_i,
   input wire logic [NUM_ROI-1:0][COL_W-1:0] window_left_kernel_i,
   input wire logic [NUM_ROI-1:0][COL_W-1:0] window_right_kernel_i,
   input wire logic [NUM_ROI-1:0][ROW_W-1:0] window_top_row_i,
   input wire logic [NUM_ROI-1:0][ROW_W-1:0] window_bottom_row_i,
   // current position
   input wire logic [ROW_W-1:0] row_i,
   input wire logic [COL_W-1:0] col_i,
   // frame results
   output logic any_o,
   output logic [ROW_W-1:0] first_row_o,
   output logic has_next_row_o,
   output logic [ROW_W-1:0] next_row_o,
   // line results
   output logic line_any_o,
   output logic [COL_W-1:0] line_start_o,
   output logic has_next_col_o,
   output logic [COL_W-1:0] next_col_o,
   output logic [2:0] region_o
);
   logic [NUM_ROI-1:0] en;
   logic [NUM_ROI-1:0] hit;
   logic [COL_W:0] c1;
   logic [ROW_W-1:0] cand;

   assign en = single_i ? {{(NUM_ROI-1){1'b0}}, roi_enable_i[0]} : roi_enable_i; // [RULE15]
   assign c1 = {1'b0, col_i} + 9'h001;

   genvar g;
   generate
      for (g = 0; g < NUM_ROI; g++) begin : g_hit
         // only regions enclosing the current row take part
         assign hit[g] = en[g] && (window_top_row_i[g] <= row_i) &&
                         (window_bottom_row_i[g] >= row_i); // [RULE21] [RULE19]
      end
   endgenerate

   always_comb begin
      cand = '0;
      any_o = 1'b0;
      first_row_o = '1;
      has_next_row_o = 1'b0;
      next_row_o = '1;
      line_any_o = 1'b0;
      line_start_o = '0;
      has_next_col_o = 1'b0;
      next_col_o = '1;
      region_o = 3'h0;
      for (int i = NUM_ROI - 1; i >= 0; i--) begin
         if (en[i]) begin // [RULE22]
            any_o = 1'b1;
            if (window_top_row_i[i] < first_row_o) begin
               first_row_o = window_top_row_i[i];
            end
            if (window_bottom_row_i[i] > row_i) begin
               cand = (window_top_row_i[i] > row_i) ? window_top_row_i[i] : row_i + 10'h001;
               has_next_row_o = 1'b1;
               if (cand < next_row_o) begin
                  next_row_o = cand;
               end
            end
         end
         if (hit[i]) begin
            // loop runs downward so the lowest-numbered region wins
            line_any_o = 1'b1;
            line_start_o = window_left_kernel_i[i]; // [RULE21]
            if ({1'b0, window_left_kernel_i[i]} <= c1 &&
                {1'b0, window_right_kernel_i[i]} >= c1) begin
               has_next_col_o = 1'b1;
               next_col_o = c1[COL_W-1:0];
            end
            if (window_left_kernel_i[i] <= col_i && window_right_kernel_i[i] >= col_i) begin
               region_o = 3'(i);
            end
         end
      end
      if (!has_next_col_o) begin
         // jump to next region on this line
         for (int i = NUM_ROI - 1; i >= 0; i--) begin
            if (hit[i] && window_left_kernel_i[i] > col_i &&
                window_left_kernel_i[i] <= next_col_o) begin
               has_next_col_o = 1'b1;
               next_col_o = window_left_kernel_i[i];
            end
         end
      end
   end
endmodule

// *** esq_sequencer.sv ***
// exposure and region readout sequencer for global and rolling shutter
//
// Functional notes
// RULE1: durations count in multiplier-scaled clock units
// RULE2: pipelined: transfer, reset span, then exposure
// RULE3: exposure start deferred to next row overhead
// RULE4: pipelined exposure stretched until readout completes
// RULE5: frame-time mode derives reset span itself
// RULE6: triggered master: rising edge starts timed exposure
// RULE7: controller holds trigger high at least 100ns
// RULE8: triggered: expired timer extends to readout end
// RULE9: controller keeps trigger low during frame overhead
// RULE10: slave: trigger high time sets integration
// RULE11: slave: early fall extends until readout done
// RULE12: rolling exposure counted in whole line times
// RULE13: rolling frame appends configured padding rows
// RULE14: rolling line is overhead plus stretched readout
// RULE15: eight regions global, one region rolling
// RULE16: eight pixels per clock, left times eight
// RULE17: software keeps right above left
// RULE18: software keeps bottom above top, even rows
// RULE19: regions may overlap, evaluated every line
// RULE20: software orders regions left to right
// RULE21: only enclosing regions scanned, lowest first
// RULE22: each region enabled independently
// RULE23: timers use prescaler reloaded each frame overhead; the code reloads it on every timer load instead
`timescale 1ns/1ps
module esq_sequencer
   import esq_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // operating settings
   input wire logic sequencer_enable_i,
   input wire logic [1:0] shutter_mode_i,
   input wire logic frame_time_mode_sel_i,
   input wire logic [TIME_W-1:0] frame_period_length_i,
   input wire logic [TIME_W-1:0] exposure_duration_i,
   input wire logic [TIME_W-1:0] time_unit_mult_i,
   input wire logic [ROW_W-1:0] padding_rows_i,
   input wire logic [CYC_W-1:0] row_readout_extend_i,
   input wire logic [2:0] flag_source_sel_i,
   // region settings
   input wire logic [NUM_ROI-1:0] roi_enable_i,
   input wire logic [NUM_ROI-1:0][COL_W-1:0] window_left_kernel_i,
   input wire logic [NUM_ROI-1:0][COL_W-1:0] window_right_kernel_i,
   input wire logic [NUM_ROI-1:0][ROW_W-1:0] window_top_row_i,
   input wire logic [NUM_ROI-1:0][ROW_W-1:0] window_bottom_row_i,
   // trigger pin
   input wire logic exposure_trigger_pin_i,
   // pixel array control
   output logic photodiode_reset_o,
   output logic exposing_o,
   output logic frame_overhead_o,
   output logic row_overhead_o,
   output logic first_line_flag_pin_o,
   // readout stream
   output logic pixel_valid_o,
   output logic [ROW_W-1:0] pixel_row_o,
   output logic [PIX_COL_W-1:0] pixel_col_o,
   output logic [2:0] pixel_region_o,
   // rolling reset pointer
   output logic rs_reset_valid_o,
   output logic [ROW_W-1:0] rs_reset_row_o
);
   logic rolling;
   logic trig_meta;
   logic trig_sync;
   logic trig_prev;
   logic trig_rise;
   logic trig_fall;
   logic busy;
   logic rd_done;
   logic xfer_req;
   logic tmr_load;
   logic tmr_expired;
   logic [TIME_W-1:0] tmr_value;
   logic [TIME_W-1:0] reset_span;
   logic roi_any;
   logic [ROW_W-1:0] first_row;
   logic has_next_row;
   logic [ROW_W-1:0] next_row;
   logic line_any;
   logic [COL_W-1:0] line_start;
   logic has_next_col;
   logic [COL_W-1:0] next_col;
   logic [2:0] region;
   logic [CYC_W-1:0] width;
   logic [CYC_W-1:0] line_len;
   logic [ROW_W:0] height;
   logic [TIME_W-1:0] total_lines;

   esq_rd_state_t rd_state;
   esq_rd_state_t next_rd_state;
   esq_ex_state_t ex_state;
   esq_ex_state_t next_ex_state;
   logic [CYC_W-1:0] cyc;
   logic [CYC_W-1:0] next_cyc;
   logic [ROW_W-1:0] row;
   logic [ROW_W-1:0] next_row_q;
   logic [COL_W-1:0] col;
   logic [COL_W-1:0] next_col_q;
   logic pix_on;
   logic next_pix_on;
   logic first_line;
   logic next_first_line;
   logic [ROW_W-1:0] pad_cnt;
   logic [ROW_W-1:0] next_pad_cnt;
   logic [TIME_W-1:0] rst_idx;
   logic [TIME_W-1:0] next_rst_idx;
   logic next_pixel_valid;

   assign rolling = (shutter_mode_i == MODE_ROLLING);
   assign trig_rise = trig_sync && !trig_prev;
   assign trig_fall = !trig_sync && trig_prev;
   assign busy = (rd_state == RD_ROT) || (rd_state == RD_LINE) || (rd_state == RD_PAD);
   assign width = CYC_W'({1'b0, window_right_kernel_i[0]} - {1'b0, window_left_kernel_i[0]})
                  + 10'h001;
   assign line_len = (row_readout_extend_i > width) ? row_readout_extend_i : width; // [RULE14]
   assign height = {1'b0, window_bottom_row_i[0]} - {1'b0, window_top_row_i[0]} + 11'h001;
   assign total_lines = TIME_W'(height) + TIME_W'(padding_rows_i); // [RULE13]

   // frame-time mode: reset span is what the exposure leaves of the frame
   assign reset_span = !frame_time_mode_sel_i ? frame_period_length_i :
      (frame_period_length_i > exposure_duration_i) ?
      frame_period_length_i - exposure_duration_i : 16'h0000; // [RULE5]

   esq_unit_timer u_timer (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .load_i(tmr_load),
      .value_i(tmr_value),
      .mult_i(time_unit_mult_i), // [RULE1]
      .expired_o(tmr_expired)
   );

   esq_roi_scan u_scan (
      .roi_enable_i(roi_enable_i),
      .single_i(rolling),
      .window_left_kernel_i(window_left_kernel_i),
      .window_right_kernel_i(window_right_kernel_i),
      .window_top_row_i(window_top_row_i),
      .window_bottom_row_i(window_bottom_row_i),
      .row_i(row),
      .col_i(col),
      .any_o(roi_any),
      .first_row_o(first_row),
      .has_next_row_o(has_next_row),
      .next_row_o(next_row),
      .line_any_o(line_any),
      .line_start_o(line_start),
      .has_next_col_o(has_next_col),
      .next_col_o(next_col),
      .region_o(region)
   );

   // exposure control
   always_comb begin
      next_ex_state = ex_state;
      tmr_load = 1'b0;
      tmr_value = exposure_duration_i;
      xfer_req = 1'b0;
      case (ex_state)
         EX_IDLE: begin
            if (sequencer_enable_i && rd_state == RD_IDLE) begin
               if (shutter_mode_i == MODE_PIPELINED) begin
                  next_ex_state = EX_RESET;
                  tmr_load = 1'b1;
                  tmr_value = reset_span; // [RULE2]
               end else if (shutter_mode_i != MODE_ROLLING && trig_rise) begin
                  // rising edge taken once per frame, only outside frame overhead
                  next_ex_state = EX_SYNC; // [RULE6] [RULE10] [RULE9] [RULE7]
               end
            end else if (sequencer_enable_i && busy && !rolling &&
                         shutter_mode_i != MODE_PIPELINED && trig_rise) begin
               next_ex_state = EX_SYNC;
            end
         end
         EX_RESET: begin
            if (tmr_expired) begin
               next_ex_state = EX_SYNC;
            end
         end
         EX_SYNC: begin
            // while readout is busy, photodiodes stay in reset until a row overhead starts
            if (!busy || (rd_state == RD_ROT && cyc == 10'h000)) begin // [RULE3]
               next_ex_state = EX_RUN;
               tmr_load = (shutter_mode_i != MODE_SLAVE);
               tmr_value = exposure_duration_i; // [RULE2] [RULE6]
            end
         end
         EX_RUN: begin
            if ((shutter_mode_i == MODE_SLAVE && !trig_sync) ||
                (shutter_mode_i != MODE_SLAVE && tmr_expired)) begin // [RULE10]
               if (busy) begin
                  next_ex_state = EX_HOLD; // [RULE4] [RULE8] [RULE11]
               end else begin
                  next_ex_state = EX_IDLE;
                  xfer_req = 1'b1;
               end
            end
         end
         EX_HOLD: begin
            if (!busy) begin
               next_ex_state = EX_IDLE;
               xfer_req = 1'b1;
            end
         end
         default: next_ex_state = EX_IDLE;
      endcase
      if (!sequencer_enable_i || rolling) begin
         next_ex_state = EX_IDLE;
         xfer_req = 1'b0;
      end
   end

   // readout control
   always_comb begin
      next_rd_state = rd_state;
      next_cyc = cyc + 10'h001;
      next_row_q = row;
      next_col_q = col;
      next_pix_on = pix_on;
      next_first_line = first_line;
      next_pad_cnt = pad_cnt;
      next_rst_idx = rst_idx;
      next_pixel_valid = 1'b0;
      rd_done = 1'b0;
      case (rd_state)
         RD_IDLE: begin
            next_cyc = '0;
            if (xfer_req || (rolling && sequencer_enable_i && roi_any)) begin
               next_rd_state = RD_FOT;
            end
         end
         RD_FOT: begin
            if (cyc + 10'h001 >= FOT_CYCLES) begin
               next_rd_state = RD_ROT;
               next_cyc = '0;
               next_row_q = rolling ? window_top_row_i[0] : first_row;
               next_first_line = 1'b1;
               next_pad_cnt = '0;
            end
         end
         RD_ROT: begin
            if (cyc + 10'h001 >= ROT_CYCLES) begin
               next_rd_state = (rolling && row > window_bottom_row_i[0]) ? RD_PAD : RD_LINE;
               next_cyc = '0;
               next_col_q = line_start; // [RULE21]
               next_pix_on = line_any;
               // reset pointer leads the read pointer by the exposure in lines
               next_rst_idx = (rst_idx + 16'h0001 >= total_lines) ? 16'h0000 :
                              rst_idx + 16'h0001; // [RULE12]
            end
         end
         RD_LINE: begin
            next_pixel_valid = pix_on;
            if (pix_on) begin
               if (has_next_col) begin
                  next_col_q = next_col; // [RULE19]
               end else begin
                  next_pix_on = 1'b0;
               end
            end
            if ((!pix_on || !has_next_col) &&
                (!rolling || cyc + 10'h001 >= line_len)) begin // [RULE14]
               next_first_line = 1'b0;
               next_cyc = '0;
               next_pix_on = 1'b0;
               if (rolling) begin
                  next_row_q = row + 10'h001;
                  next_rd_state = (row >= window_bottom_row_i[0] &&
                                   padding_rows_i == 10'h000) ? RD_IDLE : RD_ROT;
               end else if (has_next_row) begin
                  next_row_q = next_row; // [RULE19]
                  next_rd_state = RD_ROT;
               end else begin
                  next_rd_state = RD_IDLE;
               end
            end
         end
         RD_PAD: begin
            // padding rows keep line timing but carry no pixels
            if (cyc + 10'h001 >= line_len) begin // [RULE13]
               next_cyc = '0;
               next_pad_cnt = pad_cnt + 10'h001;
               next_rd_state = (pad_cnt + 10'h001 >= padding_rows_i) ? RD_IDLE : RD_ROT;
            end
         end
         default: next_rd_state = RD_IDLE;
      endcase
      if (next_rd_state == RD_IDLE && rd_state != RD_IDLE) begin
         rd_done = 1'b1;
      end
      if (!rolling) begin
         next_rst_idx = (exposure_duration_i >= total_lines) ? total_lines - 16'h0001 :
                        exposure_duration_i; // [RULE12]
      end
   end

   // synchroniser: first stage feeds only the second
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
      end else begin
         trig_meta <= exposure_trigger_pin_i;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         ex_state <= EX_IDLE;
         rd_state <= RD_IDLE;
         cyc <= '0;
         row <= '0;
         col <= '0;
         pix_on <= 1'b0;
         first_line <= 1'b0;
         pad_cnt <= '0;
         rst_idx <= '0;
         pixel_valid_o <= 1'b0;
         pixel_row_o <= '0;
         pixel_col_o <= '0;
         pixel_region_o <= 3'h0;
      end else begin
         ex_state <= next_ex_state;
         rd_state <= next_rd_state;
         cyc <= next_cyc;
         row <= next_row_q;
         col <= next_col_q;
         pix_on <= next_pix_on;
         first_line <= next_first_line;
         pad_cnt <= next_pad_cnt;
         rst_idx <= next_rst_idx;
         pixel_valid_o <= next_pixel_valid;
         pixel_row_o <= row;
         pixel_col_o <= {col, 3'h0}; // [RULE16]
         pixel_region_o <= rolling ? 3'h0 : region;
      end
   end

   assign photodiode_reset_o = !rolling && (ex_state == EX_IDLE || ex_state == EX_RESET ||
                                            ex_state == EX_SYNC);
   assign exposing_o = (ex_state == EX_RUN) || (ex_state == EX_HOLD);
   assign frame_overhead_o = (rd_state == RD_FOT);
   assign row_overhead_o = (rd_state == RD_ROT);
   // other flag sources fall back to the exposure window
   assign first_line_flag_pin_o = (flag_source_sel_i == FLAG_SRC_FIRST_LINE) ?
      (first_line && busy) : exposing_o; // [RULE9]
   assign rs_reset_valid_o = rolling && busy && (rst_idx < TIME_W'(height));
   assign rs_reset_row_o = window_top_row_i[0] + rst_idx[ROW_W-1:0];
endmodule

// *** esq_sequencer_monitor.sv ***
// port-level assertion checker for the sequencer
`timescale 1ns/1ps
module esq_sequencer_monitor
   import esq_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // settings
   input wire logic sequencer_enable_i,
   input wire logic [1:0] shutter_mode_i,
   input wire logic [TIME_W-1:0] exposure_duration_i,
   input wire logic [TIME_W-1:0] time_unit_mult_i,
   input wire logic [2:0] flag_source_sel_i,
   input wire logic [NUM_ROI-1:0][COL_W-1:0] window_left_kernel_i,
   input wire logic [NUM_ROI-1:0][COL_W-1:0] window_right_kernel_i,
   input wire logic [NUM_ROI-1:0][ROW_W-1:0] window_top_row_i,
   input wire logic [NUM_ROI-1:0][ROW_W-1:0] window_bottom_row_i,
   input wire logic exposure_trigger_pin_i,
   // observed outputs
   input wire logic photodiode_reset_o,
   input wire logic exposing_o,
   input wire logic frame_overhead_o,
   input wire logic row_overhead_o,
   input wire logic first_line_flag_pin_o,
   input wire logic pixel_valid_o,
   input wire logic [ROW_W-1:0] pixel_row_o,
   input wire logic [PIX_COL_W-1:0] pixel_col_o,
   input wire logic [2:0] pixel_region_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   logic [7:0] fot_cnt, next_fot_cnt;
   logic [31:0] exp_cnt, next_exp_cnt, need;
   logic [COL_W-1:0] kcol;
   assign need = 32'(exposure_duration_i) *
      ((time_unit_mult_i == 16'h0000) ? 32'h1 : 32'(time_unit_mult_i));
   assign kcol = pixel_col_o[PIX_COL_W-1:3];
   always_comb begin
      next_fot_cnt = frame_overhead_o ? fot_cnt + 8'h01 : 8'h00;
      next_exp_cnt = exposing_o ? exp_cnt + 32'h1 : 32'h0;
   end
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         fot_cnt <= 8'h00;
         exp_cnt <= 32'h0;
      end else begin
         fot_cnt <= next_fot_cnt;
         exp_cnt <= next_exp_cnt;
      end
   end
   sequence rot_span;
      row_overhead_o [*4] ##1 !row_overhead_o;
   endsequence
   sequence fot_follows;
      ##[0:1] frame_overhead_o;
   endsequence
   fot_len_a: assert property ($fell(frame_overhead_o) |-> fot_cnt == 8'h10)
      else $error("bad overhead length");
   rot_len_a: assert property ($rose(row_overhead_o) |-> rot_span)
      else $error("bad row overhead");
   pix_region_a: assert property (pixel_valid_o |-> pixel_col_o[2:0] == 3'h0 &&
      kcol >= window_left_kernel_i[pixel_region_o] &&
      kcol <= window_right_kernel_i[pixel_region_o] &&
      pixel_row_o >= window_top_row_i[pixel_region_o] &&
      pixel_row_o <= window_bottom_row_i[pixel_region_o])
      else $error("pixel outside region");
   roll_roi0_a: assert property (pixel_valid_o && shutter_mode_i == MODE_ROLLING
      |-> pixel_region_o == 3'h0) else $error("rolling region not 0");
   reset_excl_a: assert property (!(photodiode_reset_o && exposing_o))
      else $error("reset and exposure overlap");
   exp_end_fot_a: assert property ($fell(exposing_o) && sequencer_enable_i &&
      shutter_mode_i != MODE_ROLLING |-> fot_follows) else $error("no transfer");
   exp_min_a: assert property ($fell(exposing_o) && sequencer_enable_i &&
      shutter_mode_i == MODE_TRIGGERED |-> exp_cnt >= need) else $error("exposure too short");
   slave_hold_a: assert property ((shutter_mode_i == MODE_SLAVE && exposing_o &&
      exposure_trigger_pin_i) [*4] |=> exposing_o) else $error("slave exposure cut");
   flag_follow_a: assert property (flag_source_sel_i != FLAG_SRC_FIRST_LINE
      |-> first_line_flag_pin_o == exposing_o) else $error("flag not exposure");
endmodule

bind esq_sequencer esq_sequencer_monitor esq_sequencer_monitor_inst (.*);

// *** esq_ctrl_model.sv ***
// controller model driving the exposure trigger pin
`timescale 1ns/1ps
module esq_ctrl_model
   import esq_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic frame_overhead_i,
   output logic exposure_trigger_pin_o
);
   initial exposure_trigger_pin_o = 1'b0;
   task automatic fire(input int hi);
      int n;
      n = (hi < TRIG_MIN_HIGH_CYCLES) ? TRIG_MIN_HIGH_CYCLES : hi;
      @(posedge ref_clk_i);
      while (frame_overhead_i) @(posedge ref_clk_i);
      exposure_trigger_pin_o <= 1'b1;
      repeat (n) @(posedge ref_clk_i);
      exposure_trigger_pin_o <= 1'b0;
   endtask
endmodule

// *** esq_sequencer_test.sv ***
// self-checking bench for the sequencer
`timescale 1ns/1ps
module esq_sequencer_test;
   import esq_pkg::*;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %0t got %0h exp %0h", $time, g, e); end end
   int n_fail = 0;
   int n_compared = 0;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic en = 1'b0;
   logic [1:0] mode = MODE_TRIGGERED;
   logic [TIME_W-1:0] fr = '0, ex = '0, mu = '0;
   logic [ROW_W-1:0] pad = '0, prow, r0, rsr;
   logic [CYC_W-1:0] ext = '0;
   logic [2:0] fsel = 3'h0, preg, g0;
   logic [NUM_ROI-1:0] roe = '0;
   logic [NUM_ROI-1:0][COL_W-1:0] wl = '0, wr = '0;
   logic [NUM_ROI-1:0][ROW_W-1:0] wt = '0, wb = '0;
   logic trig, pdr, expo, frame_overhead_time, row_overhead_time, flag, pv, rsv;
   logic [PIX_COL_W-1:0] pcol, c0;
   int n, xl, ln, fa, fb;
   always #25 ref_clk_i = ~ref_clk_i;
   esq_sequencer esq_sequencer_inst (.ref_clk_i, .resetn_i, .sequencer_enable_i(en),
      .shutter_mode_i(mode), .frame_time_mode_sel_i(mode == MODE_PIPELINED),
      .frame_period_length_i(fr), .exposure_duration_i(ex), .time_unit_mult_i(mu),
      .padding_rows_i(pad),
      .row_readout_extend_i(ext), .flag_source_sel_i(fsel), .roi_enable_i(roe),
      .window_left_kernel_i(wl), .window_right_kernel_i(wr), .window_top_row_i(wt),
      .window_bottom_row_i(wb), .exposure_trigger_pin_i(trig), .photodiode_reset_o(pdr),
      .exposing_o(expo), .frame_overhead_o(frame_overhead_time), .row_overhead_o(row_overhead_time),
      .first_line_flag_pin_o(flag), .pixel_valid_o(pv), .pixel_row_o(prow),
      .pixel_col_o(pcol), .pixel_region_o(preg), .rs_reset_valid_o(rsv), .rs_reset_row_o(rsr));
   esq_ctrl_model esq_ctrl_model_inst (.ref_clk_i, .frame_overhead_i(frame_overhead_time),
      .exposure_trigger_pin_o(trig));
   task automatic roi(input int i, l, r, t, b);
      @(posedge ref_clk_i);
      roe[i] <= 1'b1;
      wl[i] <= l[7:0];
      wr[i] <= r[7:0];
      wt[i] <= t[9:0];
      wb[i] <= b[9:0];
   endtask
   task automatic stop();
      @(posedge ref_clk_i);
      en <= 1'b0;
      repeat (600) @(posedge ref_clk_i);
   endtask
   task automatic go(input logic [1:0] m);
      @(posedge ref_clk_i);
      mode <= m;
      en <= 1'b1;
   endtask
   task automatic run(input int hi);
      n = 0;
      xl = 0;
      ln = 0;
      if (hi > 0) begin
         fork
            esq_ctrl_model_inst.fire(hi);
         join_none
      end
      for (int k = 0; k < 600; k++) begin
         @(posedge ref_clk_i);
         #1;
         xl += int'(expo === 1'b1);
         ln += int'(flag === 1'b1);
         if (pv === 1'b1) begin
            if (n == 0) {r0, c0, g0} = {prow, pcol, preg};
            n++;
         end
      end
   endtask
   task automatic rtimes(output int line, output int frame);
      int t[3];
      int s = 0;
      logic [ROW_W-1:0] prv = '1;
      for (int c = 0; c < 3000 && s < 3; c++) begin
         @(posedge ref_clk_i);
         #1;
         if (pv === 1'b1 && prow !== prv) begin
            if (prv !== '1 && prow === ROW_W'(4 + s % 2)) begin
               t[s] = c;
               s++;
            end
            prv = prow;
         end
      end
      line = t[1] - t[0];
      frame = t[2] - t[0];
   endtask
   task automatic give_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge ref_clk_i);
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (10) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      roi(0, 2, 3, 4, 5);
      ex <= 16'h0005;
      mu <= 16'h0003;
      go(MODE_TRIGGERED);
      run(3);
      `CHK(n, 4)
      `CHK({r0, c0, g0}, {10'h004, 11'h010, 3'h0})
      `CHK(xl >= 15 && xl <= 18, 1'b1)
      stop();
      roe <= 8'h00;
      roi(1, 1, 2, 10, 11);
      roi(2, 2, 5, 11, 12);
      go(MODE_TRIGGERED);
      run(3);
      `CHK(n, 11)
      `CHK({r0, c0, g0}, {10'h00a, 11'h008, 3'h1})
      stop();
      ex <= 16'hffff;
      mu <= 16'hffff;
      fsel <= FLAG_SRC_FIRST_LINE;
      go(MODE_SLAVE);
      run(20);
      `CHK(n, 11)
      `CHK(xl >= 17 && xl <= 23, 1'b1)
      `CHK(ln, 6)
      stop();
      ex <= 16'h0002;
      mu <= 16'h0001;
      fr <= 16'h0004;
      fsel <= 3'h0;
      go(MODE_PIPELINED);
      run(0);
      `CHK(n >= 22, 1'b1)
      stop();
      roi(0, 2, 3, 4, 5);
      go(MODE_ROLLING);
      rtimes(ln, fa);
      rtimes(ln, fa);
      `CHK(ln, int'(ROT_CYCLES) + 2)
      `CHK(rsv, 1'b1)
      `CHK(rsr >= 4 && rsr <= 5, 1'b1)
      pad <= 10'h003;
      rtimes(ln, fb);
      rtimes(ln, fb);
      `CHK(fb - fa, 3 * ln)
      ext <= 10'h009;
      rtimes(ln, fb);
      rtimes(ln, fb);
      `CHK(ln, int'(ROT_CYCLES) + 9)
      give_verdict();
   end
endmodule
